// [design/sps_pkg.sv]
// constants shared by the serial-in parallel-out shifter and its sample fifo
//------------------------------------------------------------------------------
// Overview of operation
// RULE_01: eight stages form a chain; each stage drives its own parallel output.
// RULE_02: on each shift, stages one to seven take the preceding stage's old value.
// RULE_03: stage zero loads the AND of both serial inputs sampled before the edge.
// RULE_04: clear low zeroes all stages at once, ignoring clock and serial inputs.
// RULE_05: either serial input may gate the other; a low gate shifts in zeros.
// RULE_06: with one data input in use, the other input is held high.
// RULE_07: the old stage seven value is dropped on each shift; no serial output.
//------------------------------------------------------------------------------
package sps_pkg;
  localparam int        STAGE_COUNT = 8;
  localparam int        FIFO_DEPTH  = 32;
  localparam logic [7:0] STAGE_RESET = 8'h00;
  localparam int        SYNC_STAGES = 2;
endpackage

// [design/sps_fifo.sv]
// sample fifo with parameter width and depth, valid and ready on both sides
`timescale 1ns/100ps
module sps_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  //----------------------------------------------------------------------------
  // elaboration check
  //----------------------------------------------------------------------------
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
    $error("sps_fifo: depth must be a power of two of at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             push;
  logic             pop;

  //----------------------------------------------------------------------------
  // flags
  //----------------------------------------------------------------------------
  // extra pointer bit tells full from empty without a counter
  assign in_ready  = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign out_data  = mem[rd_ptr_r[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
    end else if (push) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_ptr_r <= '0;
    end else if (pop) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  //----------------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------------
  fifo_count_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_ptr_r - rd_ptr_r) <= (AW+1)'(DEPTH))
    else $error("fifo holds more words than its depth");
endmodule

// [design/sps_shifter.sv]
// serial-in parallel-out eight stage shifter with pin sampling and fifo
`timescale 1ns/100ps
module sps_shifter #(
  parameter int STAGES = sps_pkg::STAGE_COUNT,
  parameter int DEPTH  = sps_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // pins from the driving logic
  input  wire logic              shift_clock,
  input  wire logic              serial_a,
  input  wire logic              serial_b,
  input  wire logic              clear_n,
  input  wire logic              stage_hold,
  // parallel outputs and flow status
  output logic      [STAGES-1:0] stage_outputs,
  output logic                   sample_ready,
  output logic                   sample_lost
);

  //----------------------------------------------------------------------------
  // elaboration check
  //----------------------------------------------------------------------------
  if (STAGES < 2) begin : g_bad_stages
    $error("sps_shifter: at least two stages are needed");
  end
  // every stage takes its clear value from the shared reset word
  if (STAGES > $bits(sps_pkg::STAGE_RESET)) begin : g_bad_width
    $error("sps_shifter: more stages than the reset word covers");
  end

  logic              arst_n;
  logic [1:0]        clr_sync_r;
  logic [1:0]        clk_sync_r;
  logic [1:0]        a_sync_r;
  logic [1:0]        b_sync_r;
  logic [1:0]        hold_sync_r;
  logic              clk_prev_r;
  logic              a_prev_r;
  logic              b_prev_r;
  logic              shift_edge;
  logic              sample_bit;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_bit;
  logic              stage_pop;
  logic [STAGES-1:0] stage_r;

  //----------------------------------------------------------------------------
  // clear handling
  //----------------------------------------------------------------------------
  // clear asserts at once through the async term; its release reaches the
  // chain unsynchronised, which is safe only because the fifo leaves clear
  // empty, so no stage can move until a synchronised edge is accepted
  // RULE_04: async clear of stages
  assign arst_n = reset_n & clear_n;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      clr_sync_r <= 2'h0;
    end else begin
      clr_sync_r <= {clr_sync_r[0], 1'b1};
    end
  end

  //----------------------------------------------------------------------------
  // pin synchronisers
  //----------------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_sync_r  <= 2'h0;
      a_sync_r    <= 2'h0;
      b_sync_r    <= 2'h0;
      hold_sync_r <= 2'h0;
    end else begin
      clk_sync_r  <= {clk_sync_r[0], shift_clock};
      a_sync_r    <= {a_sync_r[0], serial_a};
      b_sync_r    <= {b_sync_r[0], serial_b};
      hold_sync_r <= {hold_sync_r[0], stage_hold};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_prev_r <= 1'b0;
      a_prev_r   <= 1'b0;
      b_prev_r   <= 1'b0;
    end else begin
      clk_prev_r <= clk_sync_r[1];
      a_prev_r   <= a_sync_r[1];
      b_prev_r   <= b_sync_r[1];
    end
  end

  //----------------------------------------------------------------------------
  // edge detect and gated serial data
  //----------------------------------------------------------------------------
  // edges seen while clear is held or still releasing are dropped
  assign shift_edge = clk_sync_r[1] && !clk_prev_r && clr_sync_r[1];
  // RULE_03: and of inputs before edge
  // data is taken from the sample one cycle before the edge, which stands in
  // for setup time; RULE_05 and RULE_06 gating falls out of the same and
  assign sample_bit = a_prev_r & b_prev_r;

  //----------------------------------------------------------------------------
  // sample fifo
  //----------------------------------------------------------------------------
  // a held chain lets samples queue; once full further edges are lost
  assign stage_pop = fifo_out_valid && !hold_sync_r[1];

  sps_fifo #(
    .WIDTH (1),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .arst_n    (arst_n),
    .in_valid  (shift_edge),
    .in_ready  (fifo_in_ready),
    .in_data   (sample_bit),
    .out_valid (fifo_out_valid),
    .out_ready (stage_pop),
    .out_data  (fifo_out_bit)
  );

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_ready <= 1'b0;
      sample_lost  <= 1'b0;
    end else begin
      sample_ready <= fifo_in_ready && clr_sync_r[1];
      sample_lost  <= shift_edge && !fifo_in_ready;
    end
  end

  //----------------------------------------------------------------------------
  // stage chain
  //----------------------------------------------------------------------------
  // RULE_01: one flop per stage
  // RULE_03: stage zero takes the gated bit
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_r[0] <= sps_pkg::STAGE_RESET[0];
    end else if (stage_pop) begin
      stage_r[0] <= fifo_out_bit;
    end
  end

  for (genvar i = 1; i < STAGES; i++) begin : g_stage
    // RULE_02: take preceding stage
    // RULE_07: last stage simply drops its old value
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        stage_r[i] <= sps_pkg::STAGE_RESET[i];
      end else if (stage_pop) begin
        stage_r[i] <= stage_r[i-1];
      end
    end
  end

  // RULE_01: parallel outputs from flops
  assign stage_outputs = stage_r;

  //----------------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------------
  clear_zeroes_a: assert property (@(posedge core_clk) disable iff (!reset_n) // RULE_04
    !clear_n |-> stage_outputs == '0)
    else $error("stages not zero while clear is low");

  chain_shift_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_02
    stage_pop |=> stage_outputs[STAGES-1:1] == $past(stage_outputs[STAGES-2:0]))
    else $error("stage did not take its predecessor");

  stage_load_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_03
    shift_edge && fifo_in_ready && !fifo_out_valid && !hold_sync_r[1]
    |=> stage_pop && fifo_out_bit == ($past(a_prev_r) & $past(b_prev_r)))
    else $error("sampled bit is not the and of both inputs");

  hold_stable_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_07
    !stage_pop |=> $stable(stage_outputs))
    else $error("chain moved without a shift");

  edge_to_stage_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_01
    shift_edge && !fifo_out_valid && !hold_sync_r[1] && !stage_hold
    |=> ##[0:2] stage_pop)
    else $error("sample did not reach the chain in time");

  stage_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_03
    stage_pop |=> stage_outputs[0] == $past(fifo_out_bit))
    else $error("stage zero did not take the queued bit");

  // lost must mark exactly the edges that a full queue refused
  lost_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    shift_edge && !fifo_in_ready |=> sample_lost)
    else $error("refused edge was not flagged as lost");

  lost_quiet_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !shift_edge || fifo_in_ready |=> !sample_lost)
    else $error("lost flag raised without a refused edge");

  // an empty queue can always take a sample once clear has settled
  ready_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !fifo_out_valid && clr_sync_r[1] |=> sample_ready)
    else $error("empty queue not reported ready");

  shift_seen_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    stage_pop && fifo_out_bit);
  fifo_full_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    shift_edge && !fifo_in_ready);
  clear_mid_c: cover property (@(posedge core_clk) disable iff (!reset_n)
    stage_outputs != '0 ##1 !clear_n);
  hold_drain_c: cover property (@(posedge core_clk) disable iff (!arst_n)
    hold_sync_r[1] ##1 !hold_sync_r[1] && stage_pop);
endmodule

// [bench/sps_pin_drv.sv]
// pin driver model for the logic feeding the shifter
`timescale 1ns/100ps
module sps_pin_drv (
  // clock
  input  wire logic core_clk,
  // pins
  output logic      shift_clock,
  output logic      serial_a,
  output logic      serial_b,
  output logic      clear_n
);
  initial begin
    shift_clock = 1'b0;
    serial_a    = 1'b1;
    serial_b    = 1'b1;
    clear_n     = 1'b1;
  end
  // clear pin level, driven at the falling edge by the caller
  task automatic set_clear(input logic level);
    clear_n = level;
  endtask
  // gated data entry
  // gap sets pace: 1 is the fastest the sampler allows
  task automatic shift_bit(input logic a, input logic b, input int gap);
    @(negedge core_clk);
    serial_a = a;
    serial_b = b;
    repeat (gap) @(negedge core_clk);
    shift_clock = 1'b1;
    repeat (gap) @(negedge core_clk);
    shift_clock = 1'b0;
    repeat (gap) @(negedge core_clk);
  endtask
endmodule

// [bench/testbench.sv]
// self-checking bench for the eight stage shifter
`timescale 1ns/100ps
module testbench;
  logic       core_clk     = 1'b0;
  logic       reset_n      = 1'b0;
  logic       stage_hold   = 1'b0;
  logic       shift_clock;
  logic       serial_a;
  logic       serial_b;
  logic       clear_n;
  logic [7:0] stage_outputs;
  logic       sample_ready;
  logic       sample_lost;
  logic [7:0] exp_q        = 8'h00;
  int         num_errors   = 0;
  int         total_checks = 0;
  int         lost_count   = 0;
  int         cycle_count  = 0;

  always #50 core_clk = ~core_clk;

  sps_pin_drv drv (
    .core_clk    (core_clk),
    .shift_clock (shift_clock),
    .serial_a    (serial_a),
    .serial_b    (serial_b),
    .clear_n     (clear_n)
  );
  sps_shifter #(.STAGES(8), .DEPTH(32)) dut (
    .core_clk      (core_clk),
    .reset_n       (reset_n),
    .shift_clock   (shift_clock),
    .serial_a      (serial_a),
    .serial_b      (serial_b),
    .clear_n       (clear_n),
    .stage_hold    (stage_hold),
    .stage_outputs (stage_outputs),
    .sample_ready  (sample_ready),
    .sample_lost   (sample_lost)
  );

  //----------------------------------------
  // helpers
  //----------------------------------------
  // lost pulses last one cycle, so count them on every edge
  always @(posedge core_clk) begin
    cycle_count++;
    if (sample_lost === 1'b1) lost_count++;
    if (cycle_count == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic a, input logic b, input int gap);
    drv.shift_bit(a, b, gap);
    exp_q = {exp_q[6:0], a & b};
  endtask
  task automatic stop_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  //----------------------------------------
  // scenarios
  //----------------------------------------
  task automatic t_gate();
    for (int i = 0; i < 4; i++) begin
      send(i[1], i[0], 3);
      check(stage_outputs, exp_q);
    end
  endtask
  task automatic t_walk();
    logic [11:0] pat;
    pat = 12'hd6b;
    for (int i = 0; i < 12; i++) begin
      send(pat[i], 1'b1, (i % 3 == 0) ? 6 : 3);
      check(stage_outputs, exp_q);
    end
    check(stage_outputs, exp_q);
  endtask
  task automatic t_clear();
    @(negedge core_clk);
    drv.set_clear(1'b0);
    #1 check(stage_outputs, 8'h00);
    drv.shift_bit(1'b1, 1'b1, 3);
    check(stage_outputs, 8'h00);
    drv.set_clear(1'b1);
    repeat (6) @(negedge core_clk);
    exp_q = 8'h00;
    send(1'b1, 1'b1, 3);
    check(stage_outputs, exp_q);
  endtask
  // queue fills while the chain is stalled; one edge past full is lost
  task automatic t_fifo();
    logic [7:0] held;
    held = exp_q;
    @(negedge core_clk);
    stage_hold = 1'b1;
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < 32; i++) begin
      send(i[0] ^ i[2], 1'b1, 3);
    end
    check(stage_outputs, held);
    check({7'h00, sample_ready}, 8'h00);
    drv.shift_bit(1'b1, 1'b1, 3);
    check(lost_count[7:0], 8'h01);
    stage_hold = 1'b0;
    repeat (48) @(negedge core_clk);
    check(stage_outputs, exp_q);
    check({7'h00, sample_ready}, 8'h01);
  endtask

  //----------------------------------------
  // main sequence
  //----------------------------------------
  initial begin
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (6) @(negedge core_clk);
    check(stage_outputs, 8'h00);
    check({7'h00, sample_ready}, 8'h01);
    t_gate();
    t_walk();
    t_clear();
    t_fifo();
    stop_test();
  end
endmodule
